// File: src/tape_status_pkg.sv
// constants, field layouts and carrier types for the tape status and interrupt block
// ============================================================================
// What this block does
// R01 - status one bit 0 shows selected transport ready to take commands
// R02 - busy bit set while operating; raised no later than the accepting reply
// R03 - interrupt bit shows a selected interrupt is active; clears with it
// R04 - data bit set when a transfer may occur; cleared by a data request
// R05 - end of operation sets when motion completes, rewind-unload excepted
// R06 - alarm sets with end of tape, parity, lost data, file mark, ready change
// R07 - lost data sets in read when a frame meets a full holding register
// R08 - lost data rejects data requests, blocks data interrupt until next function
// R09 - bit 7 shows protect switch of the selected transport enabled
// R10 - parity error on transfer error or wrong-mode mark; not checked on backspace
// R11 - bits 9, 10, 11 report end of tape, load point, file mark
// R12 - active bit held about 4 ms after write or read, 11 ms after backspace
// R13 - status two bit 0 flags 556 bpi, bit 1 flags 800 bpi
// R14 - status two bit 3 flags seven-track mode of the selected unit
// R15 - status two bit 4 flags write ring present with tape loaded
// R16 - clear interrupt drops all selections and all active interrupts
// R17 - reselecting clears that interrupt; alarm stays while its cause persists
// R18 - clear controller clears interrupts; data transfer clears data interrupt
// R19 - respond only to the equipment number set on the address switch
// R20 - one protect switch per transport; lamp lit when protected unit selected
// R21 - even parity mode lamp and parity error lamp
// R22 - connect lamp lit while the controller is connected on the channel
// R23 - host reads status one with code 01, status two with code 10
// R24 - function bit 0 clears controller, bit 1 clears interrupts only
// R25 - bits 2..4 select data, end, alarm interrupts; clears before selections
// R26 - undefined status bits read zero
package tape_status_pkg;
    // ========================================================================
    // channel function codes
    localparam logic [1:0] DCODE_DATA = 2'h0;
    localparam logic [1:0] DCODE_FUNC = 2'h1;
    localparam logic [1:0] DCODE_STAT2 = 2'h2;
    // control function word fields
    localparam int CF_CLR_CTL = 0;
    localparam int CF_CLR_INT = 1;
    localparam int CF_SEL_DATA = 2;
    localparam int CF_SEL_EOP = 3;
    localparam int CF_SEL_ALARM = 4;
    localparam int CF_MOTION_LSB = 7;
    // status one bit positions
    localparam int S1_READY = 0;
    localparam int S1_BUSY = 1;
    localparam int S1_INT = 2;
    localparam int S1_DATA = 3;
    localparam int S1_EOP = 4;
    localparam int S1_ALARM = 5;
    localparam int S1_LOST = 6;
    localparam int S1_PROT = 7;
    localparam int S1_PARITY = 8;
    localparam int S1_EOT = 9;
    localparam int S1_LOADPT = 10;
    localparam int S1_FMARK = 11;
    localparam int S1_ACTIVE = 12;
    // status two bit positions
    localparam int S2_D556 = 0;
    localparam int S2_D800 = 1;
    localparam int S2_SEVEN = 3;
    localparam int S2_WENABLE = 4;
    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [3:0] MOTION_RST = 4'h0;
    // active hold times
    localparam int CLK_KHZ = 40000;
    localparam int HOLD_RW_MS = 4;
    localparam int HOLD_BS_MS = 11;
    localparam int HOLD_RW_CYC = HOLD_RW_MS * CLK_KHZ;
    localparam int HOLD_BS_CYC = HOLD_BS_MS * CLK_KHZ;
    localparam int HOLD_W = 20;

    // one channel transfer offered by the host
    typedef struct packed {
        logic strobe;
        logic dir_in;
        logic [3:0] equip;
        logic [1:0] dcode;
        logic [15:0] word;
    } chan_req_t;

    // conditions of the selected transport
    typedef struct packed {
        logic ready;
        logic eot;
        logic load_point;
        logic d556;
        logic d800;
        logic seven_track;
        logic write_ring;
        logic loaded;
        logic even_mode;
        logic [2:0] unit;
    } unit_stat_t;

    // one-cycle events, plus the motion_on and read_mode levels, from the motion and data paths
    typedef struct packed {
        logic motion_on;
        logic motion_done;
        logic done_unload;
        logic done_rw;
        logic done_bs;
        logic frame_in;
        logic read_mode;
        logic parity_err;
        logic fm_sensed;
        logic unit_select_op;
    } tape_ev_t;
endpackage

// File: src/tape_status.sv
// status words, interrupt clearing, address match and panel lamps of the tape controller
`timescale 1ns/1ps
module tape_status #(
    parameter int HOLD_RW = tape_status_pkg::HOLD_RW_CYC,
    parameter int HOLD_BS = tape_status_pkg::HOLD_BS_CYC,
    parameter int UNITS = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire tape_status_pkg::chan_req_t i_req,
    input wire logic [3:0] i_equip_sw,
    input wire logic [UNITS-1:0] i_protect_sw,
    input wire tape_status_pkg::unit_stat_t i_unit,
    input wire tape_status_pkg::tape_ev_t i_ev,
    input wire logic [5:0] i_rd_char,
    output logic o_reply,
    output logic o_reject,
    output logic [15:0] o_a_word,
    output logic o_interrupt,
    output logic o_motion_start,
    output logic [3:0] o_motion_code,
    output logic o_connect_lamp,
    output logic o_protect_lamp,
    output logic o_even_parity_lamp,
    output logic o_parity_error_lamp
);
    // ========================================================================
    // request decode
    logic hit;
    logic is_func;
    logic is_data;
    logic func_ok;
    logic data_ok;
    logic [15:0] fw;
    logic [3:0] mcode;
    logic busy_r;
    logic lost_r;
    logic data_r;
    logic eop_r;
    logic alarm_r;
    logic parity_r;
    logic fmark_r;
    logic active_r;
    logic sel_data_r;
    logic sel_eop_r;
    logic sel_alarm_r;
    logic irq_data_r;
    logic irq_eop_r;
    logic irq_alarm_r;
    logic ready_d_r;
    logic ready_seen_r;
    // counter wide enough for the longer of the two hold spans
    localparam int HOLD_W_L = tape_status_pkg::HOLD_W;
    logic [HOLD_W_L-1:0] hold_r;
    // assembled status words
    logic [15:0] stat1;
    logic [15:0] stat2;
    logic any_clear;
    logic alarm_ev;
    logic alarm_pulse;
    logic par_ev;
    logic eop_ev;
    logic data_ev;
    logic lost_ev;
    logic ready_chg;
    logic prot_sel;

    assign hit = i_req.strobe && (i_req.equip == i_equip_sw); // R19
    assign fw = i_req.word;
    assign mcode = fw[tape_status_pkg::CF_MOTION_LSB +: 4];
    assign is_func = hit && !i_req.dir_in && (i_req.dcode == tape_status_pkg::DCODE_FUNC);
    assign is_data = hit && (i_req.dcode == tape_status_pkg::DCODE_DATA);
    // clears alone pass even when the unit is not ready or busy
    assign func_ok = is_func && ((i_unit.ready && !busy_r) || (mcode == 4'h0 && fw[6:5] == 2'h0));
    assign data_ok = is_data && data_r && !lost_r; // R08
    assign any_clear = func_ok && (fw[tape_status_pkg::CF_CLR_CTL] || fw[tape_status_pkg::CF_CLR_INT]); // R16

    // event terms
    assign prot_sel = i_protect_sw[i_unit.unit];
    // no ready change is claimed on the first cycle after reset
    assign ready_chg = ready_seen_r && (i_unit.ready != ready_d_r) && !i_ev.unit_select_op;
    assign lost_ev = i_ev.frame_in && i_ev.read_mode && data_r; // R07
    assign data_ev = i_ev.frame_in && !lost_r && !lost_ev;
    assign eop_ev = i_ev.motion_done && !i_ev.done_unload; // R05
    // a parity error while backspacing is neither flagged nor alarmed
    assign par_ev = i_ev.parity_err && (o_motion_code != 4'h3); // R10
    assign alarm_pulse = par_ev || lost_ev || i_ev.fm_sensed || ready_chg; // R06
    assign alarm_ev = i_unit.eot || alarm_pulse; // R06

    // ========================================================================
    // status words, undefined bits zero
    always_comb begin
        stat1 = 16'h0000; // R26
        stat1[tape_status_pkg::S1_READY] = i_unit.ready; // R01
        stat1[tape_status_pkg::S1_BUSY] = busy_r; // R02
        stat1[tape_status_pkg::S1_INT] = irq_data_r || irq_eop_r || irq_alarm_r; // R03
        stat1[tape_status_pkg::S1_DATA] = data_r; // R04
        stat1[tape_status_pkg::S1_EOP] = eop_r; // R05
        stat1[tape_status_pkg::S1_ALARM] = alarm_r; // R06
        stat1[tape_status_pkg::S1_LOST] = lost_r; // R07
        stat1[tape_status_pkg::S1_PROT] = prot_sel; // R09
        stat1[tape_status_pkg::S1_PARITY] = parity_r; // R10
        stat1[tape_status_pkg::S1_EOT] = i_unit.eot; // R11
        stat1[tape_status_pkg::S1_LOADPT] = i_unit.load_point; // R11
        stat1[tape_status_pkg::S1_FMARK] = fmark_r; // R11
        stat1[tape_status_pkg::S1_ACTIVE] = active_r; // R12
        stat2 = 16'h0000; // R26
        stat2[tape_status_pkg::S2_D556] = i_unit.d556; // R13
        stat2[tape_status_pkg::S2_D800] = i_unit.d800; // R13
        stat2[tape_status_pkg::S2_SEVEN] = i_unit.seven_track; // R14
        stat2[tape_status_pkg::S2_WENABLE] = i_unit.write_ring && i_unit.loaded; // R15
    end

    // ========================================================================
    // channel answer: one cycle after the strobe, reply or reject
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reply <= 1'b0;
            o_reject <= 1'b0;
            o_a_word <= tape_status_pkg::WORD_RST;
        end else begin
            o_reply <= 1'b0;
            o_reject <= 1'b0;
            if (hit) begin
                if (i_req.dir_in && i_req.dcode == tape_status_pkg::DCODE_FUNC) begin
                    o_reply <= 1'b1; // R23
                    o_a_word <= stat1;
                end else if (i_req.dir_in && i_req.dcode == tape_status_pkg::DCODE_STAT2) begin
                    o_reply <= 1'b1; // R23
                    o_a_word <= stat2;
                end else if (func_ok || data_ok) begin
                    o_reply <= 1'b1;
                    if (data_ok && i_req.dir_in) begin
                        o_a_word <= {10'h000, i_rd_char};
                    end
                end else begin
                    o_reject <= 1'b1; // R08
                end
            end
        end
    end

    // motion hand-off; busy rises on the same edge as the reply
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_motion_start <= 1'b0;
            o_motion_code <= tape_status_pkg::MOTION_RST;
            busy_r <= 1'b0;
        end else begin
            o_motion_start <= func_ok && (mcode != 4'h0);
            if (func_ok && mcode != 4'h0) begin
                o_motion_code <= mcode;
            end
            if (func_ok && mcode != 4'h0) begin
                busy_r <= 1'b1; // R02
            end else if (i_ev.motion_done) begin
                busy_r <= 1'b0;
            end
        end
    end

    // ========================================================================
    // condition flags; a setting event wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_r <= 1'b0;
            lost_r <= 1'b0;
            eop_r <= 1'b0;
            alarm_r <= 1'b0;
            parity_r <= 1'b0;
            fmark_r <= 1'b0;
            ready_d_r <= 1'b0;
            ready_seen_r <= 1'b0;
        end else begin
            ready_d_r <= i_unit.ready;
            ready_seen_r <= 1'b1;
            if (data_ev) begin
                data_r <= 1'b1; // R04
            end else if (data_ok || (func_ok && fw[tape_status_pkg::CF_CLR_CTL])) begin
                data_r <= 1'b0; // R04
            end
            if (lost_ev) begin
                lost_r <= 1'b1; // R07
            end else if (func_ok) begin
                lost_r <= 1'b0; // R08
            end
            if (eop_ev) begin
                eop_r <= 1'b1; // R05
            end else if (func_ok && mcode != 4'h0) begin
                eop_r <= 1'b0;
            end
            if (alarm_ev) begin
                alarm_r <= 1'b1; // R06
            end else if (func_ok && (fw[tape_status_pkg::CF_CLR_CTL] || mcode != 4'h0)) begin
                alarm_r <= 1'b0;
            end
            // parity is never judged while backspacing
            if (par_ev) begin
                parity_r <= 1'b1; // R10
            end else if (func_ok && (fw[tape_status_pkg::CF_CLR_CTL] || mcode != 4'h0)) begin
                parity_r <= 1'b0;
            end
            if (i_ev.fm_sensed) begin
                fmark_r <= 1'b1; // R11
            end else if (func_ok && (fw[tape_status_pkg::CF_CLR_CTL] || mcode != 4'h0)) begin
                fmark_r <= 1'b0; // R24
            end
        end
    end

    // ========================================================================
    // interrupt selections; clears act first, then the same word's selections
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sel_data_r <= 1'b0;
            sel_eop_r <= 1'b0;
            sel_alarm_r <= 1'b0;
        end else if (func_ok) begin
            sel_data_r <= fw[tape_status_pkg::CF_SEL_DATA] || (sel_data_r && !any_clear); // R25
            sel_eop_r <= fw[tape_status_pkg::CF_SEL_EOP] || (sel_eop_r && !any_clear); // R25
            sel_alarm_r <= fw[tape_status_pkg::CF_SEL_ALARM] || (sel_alarm_r && !any_clear); // R25
        end
    end

    // active interrupts; an event in the clearing cycle still sets
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_data_r <= 1'b0;
            irq_eop_r <= 1'b0;
            irq_alarm_r <= 1'b0;
        end else begin
            if (data_ev && sel_data_r) begin
                irq_data_r <= 1'b1;
            end else if (any_clear || data_ok || lost_r ||
                         (func_ok && fw[tape_status_pkg::CF_SEL_DATA])) begin
                irq_data_r <= 1'b0; // R18
            end
            if (eop_ev && sel_eop_r) begin
                irq_eop_r <= 1'b1;
            end else if (any_clear || (func_ok && fw[tape_status_pkg::CF_SEL_EOP])) begin
                irq_eop_r <= 1'b0; // R17
            end
            // a persisting end of tape keeps the alarm interrupt on reselection,
            // but a held level may not outvote a clear the way a one-cycle event does
            if (sel_alarm_r && (alarm_pulse || (i_unit.eot && !any_clear))) begin
                irq_alarm_r <= 1'b1;
            end else if (any_clear) begin
                irq_alarm_r <= 1'b0; // R16
            end else if (func_ok && fw[tape_status_pkg::CF_SEL_ALARM] && !i_unit.eot) begin
                irq_alarm_r <= 1'b0; // R17
            end
        end
    end

    // interrupt line to the channel
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_interrupt <= 1'b0;
        end else begin
            o_interrupt <= irq_data_r || irq_eop_r || irq_alarm_r; // R03
        end
    end

    // ========================================================================
    // controller active with post-operation hold
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            active_r <= 1'b0;
            hold_r <= '0;
        end else begin
            if (i_ev.motion_done && i_ev.done_bs) begin
                hold_r <= HOLD_W_L'(HOLD_BS); // R12
            end else if (i_ev.motion_done && i_ev.done_rw) begin
                hold_r <= HOLD_W_L'(HOLD_RW); // R12
            end else if (hold_r != '0) begin
                hold_r <= hold_r - 1'b1;
            end
            // active from the accepting edge, before the transport reports motion
            active_r <= (func_ok && mcode != 4'h0) || o_motion_start || i_ev.motion_on || (hold_r != '0) ||
                        (i_ev.motion_done && (i_ev.done_bs || i_ev.done_rw)); // R12
        end
    end

    // ========================================================================
    // panel lamps; connect tracks the last equipment addressed
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_connect_lamp <= 1'b0;
            o_protect_lamp <= 1'b0;
            o_even_parity_lamp <= 1'b0;
            o_parity_error_lamp <= 1'b0;
        end else begin
            if (i_req.strobe) begin
                o_connect_lamp <= hit; // R22
            end
            o_protect_lamp <= prot_sel; // R20
            o_even_parity_lamp <= i_unit.even_mode; // R21
            o_parity_error_lamp <= parity_r; // R21
        end
    end

    // ========================================================================
    // checks
    // channel answers and address match
    a_busy_with_reply: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R02
        (func_ok && mcode != 4'h0) |=> (busy_r && o_reply)) else $error("busy not raised with reply");
    a_busy_reject: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R02
        (is_func && busy_r && mcode != 4'h0) |=> o_reject) else $error("motion taken while busy");
    a_reply_only_hit: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R19
        (o_reply || o_reject) |-> $past(hit)) else $error("answer without address match");
    // data path and lost data
    a_lost_rejects: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R08
        (lost_r && is_data) |=> o_reject) else $error("data request taken after lost data");
    a_lost_sets: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R07
        lost_ev |=> lost_r ##1 (lost_r || $past(func_ok))) else $error("lost data not held");
    a_data_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R18
        (data_ok && !data_ev) |=> (!data_r && !irq_data_r)) else $error("data transfer left data flag");
    // interrupts and clears
    a_clear_drops: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R16
        (any_clear && !eop_ev) |=> !irq_eop_r) else $error("clear left end interrupt");
    a_clear_alarm: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R16
        (any_clear && !alarm_pulse && !fw[tape_status_pkg::CF_SEL_ALARM]) |=> !irq_alarm_r)
        else $error("alarm kept after clear");
    a_alarm_stays: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R17
        (irq_alarm_r && i_unit.eot && !any_clear) |=> irq_alarm_r) else $error("alarm dropped with end of tape");
    a_int_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R03
        stat1[tape_status_pkg::S1_INT] |=> o_interrupt) else $error("interrupt line lags status");
    // status, hold and lamps
    a_parity_backspace: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
        (i_ev.parity_err && !par_ev && !parity_r) |=> !parity_r) else $error("parity judged on backspace");
    a_active_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
        (i_ev.motion_done && i_ev.done_rw) |=> active_r [*3]) else $error("active not held");
    a_connect_lamp: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R22
        hit |=> o_connect_lamp) else $error("connect lamp dark after match");
    a_protect_lamp: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R20
        prot_sel |=> o_protect_lamp) else $error("protect lamp dark for protected unit");

    // cover points for the main scenarios
    c_status_read: cover property (@(posedge i_clk) hit && i_req.dir_in ##1 o_reply);
    c_lost_data: cover property (@(posedge i_clk) lost_ev ##1 is_data ##1 o_reject);
    c_alarm_irq: cover property (@(posedge i_clk) sel_alarm_r && alarm_ev ##1 irq_alarm_r);
    c_clear_int: cover property (@(posedge i_clk) any_clear ##2 !o_interrupt);
    c_backspace_hold: cover property (@(posedge i_clk) i_ev.motion_done && i_ev.done_bs ##1 active_r);
endmodule

// File: tb/tape_unit_model.sv
// behavioural tape transport that answers the controller's motion starts
`timescale 1ns/1ps
module tape_unit_model #(
    parameter int RUN = 30
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [3:0] i_code,
    input wire logic i_eot,
    input wire logic [2:0] i_pulse,
    output tape_status_pkg::unit_stat_t o_unit,
    output tape_status_pkg::tape_ev_t o_ev
);
    int cnt_r;
    logic [3:0] code_r;
    logic done_r;
    // ========================================================================
    // motion timer: tape runs a fixed span, then reports completion once
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= 0;
            code_r <= 4'h0;
            done_r <= 1'b0;
        end else begin
            done_r <= (cnt_r == 1);
            if (i_start) begin
                cnt_r <= RUN;
                code_r <= i_code;
            end else if (cnt_r != 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
    // ready held steady so no spurious ready change reaches the alarm
    always_comb begin
        o_unit = '0;
        o_unit.ready = 1'b1;
        o_unit.eot = i_eot;
        o_unit.d556 = 1'b1;
        o_unit.seven_track = 1'b1;
        o_unit.write_ring = 1'b1;
        o_unit.loaded = 1'b1;
        o_unit.even_mode = 1'b1;
        o_unit.unit = 3'h1;
        o_ev = '0;
        o_ev.motion_on = (cnt_r != 0);
        o_ev.motion_done = done_r;
        o_ev.done_rw = done_r && (code_r inside {4'h1, 4'h2, 4'h5});
        o_ev.done_bs = done_r && (code_r == 4'h3);
        o_ev.done_unload = done_r && (code_r == 4'hc);
        o_ev.read_mode = (code_r == 4'h2);
        o_ev.frame_in = i_pulse[0];
        o_ev.parity_err = i_pulse[1];
        o_ev.fm_sensed = i_pulse[2];
    end
endmodule

// File: tb/tb_tape_ctrl_status_interrupt.sv
// self-checking bench for the tape status and interrupt block
`timescale 1ns/1ps
module tb_tape_ctrl_status_interrupt;
    logic clk, rst, eot, rep, rej, ms, cl, pl, el, perl, irq;
    tape_status_pkg::chan_req_t req;
    tape_status_pkg::unit_stat_t unit;
    tape_status_pkg::tape_ev_t ev;
    logic [3:0] eq, mc, sw;
    logic [7:0] psw;
    logic [5:0] rdc;
    logic [2:0] evp;
    logic [15:0] a, aw;
    int miscompares, num_checks;
    // ========================================================================
    // clock, design and transport
    always #12.5 clk = ~clk;
    tape_status #(.HOLD_RW(20), .HOLD_BS(50), .UNITS(8)) dut_u (.i_clk(clk), .i_sys_rst(rst),
        .i_req(req), .i_equip_sw(sw), .i_protect_sw(psw), .i_unit(unit), .i_ev(ev),
        .i_rd_char(rdc), .o_reply(rep), .o_reject(rej), .o_a_word(aw), .o_interrupt(irq),
        .o_motion_start(ms), .o_motion_code(mc), .o_connect_lamp(cl), .o_protect_lamp(pl),
        .o_even_parity_lamp(el), .o_parity_error_lamp(perl));
    tape_unit_model #(.RUN(30)) unit_u (.i_clk(clk), .i_sys_rst(rst), .i_start(ms), .i_code(mc),
        .i_eot(eot), .i_pulse(evp), .o_unit(unit), .o_ev(ev));
    // ========================================================================
    // comparison and verdict
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one channel transfer: held one edge, answer taken the cycle after
    task automatic xfer(input logic dir, input logic [1:0] dc, input logic [15:0] w);
        @(negedge clk);
        req = '{1'b1, dir, eq, dc, w};
        @(negedge clk);
        req.strobe = 1'b0;
        a = aw;
    endtask
    task automatic ctl(input logic [15:0] w, input logic ok);
        xfer(1'b0, tape_status_pkg::DCODE_FUNC, w);
        chk({rep, rej}, {ok, !ok});
    endtask
    task automatic stat(input logic [15:0] exp, input logic [15:0] mask);
        xfer(1'b1, tape_status_pkg::DCODE_FUNC, 16'h0000);
        chk(a & mask, exp);
    endtask
    task automatic pulse(input int idx);
        @(negedge clk);
        evp[idx] = 1'b1;
        @(negedge clk);
        evp = 3'h0;
    endtask
    // poll status until busy drops, bounded
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            xfer(1'b1, tape_status_pkg::DCODE_FUNC, 16'h0000);
            if (a[1] === 1'b0) break;
        end
        chk(a[tape_status_pkg::S1_BUSY], 1'b0);
    endtask
    // ========================================================================
    // watchdog sized well above the planned run
    initial begin
        #(25 * 20000);
        miscompares++;
        final_report();
    end
    // ========================================================================
    // test sequence
    initial begin
        clk = 0;
        rst = 1;
        req = '0;
        eq = 4'h5;
        sw = 4'h5;
        psw = 8'h02;
        rdc = 6'h2a;
        eot = 0;
        evp = 3'h0;
        miscompares = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 0;
        // static words, lamps and address match
        stat(16'h0081, 16'hffff);
        chk({cl, pl, el, perl}, 4'he);
        psw = 8'h00;
        stat(16'h0001, 16'hffff);
        chk(pl, 1'b0);
        psw = 8'h02;
        xfer(1'b0, tape_status_pkg::DCODE_STAT2, 16'h0000);
        chk({rep, rej}, 2'h1);
        xfer(1'b1, tape_status_pkg::DCODE_STAT2, 16'h0000);
        chk(a, 16'h0019);
        eq = 4'h6;
        xfer(1'b1, tape_status_pkg::DCODE_FUNC, 16'h0000);
        chk({rep, rej, cl}, 3'h0);
        eq = 4'h5;
        $display("test static done");
        // write with end interrupt and a parity error
        ctl(16'h0088, 1'b1);
        chk({ms, mc}, 5'h11);
        stat(16'h1083, 16'hffff);
        ctl(16'h0080, 1'b0);
        pulse(1);
        wait_idle();
        stat(16'h11b5, 16'hffff);
        chk({irq, perl}, 2'h3);
        repeat (30) @(negedge clk);
        stat(16'h01b5, 16'hffff);
        $display("test write done");
        // interrupt clearing
        ctl(16'h0008, 1'b1);
        stat(16'h01b1, 16'hffff);
        chk(irq, 1'b0);
        eot = 1;
        ctl(16'h0010, 1'b1);
        stat(16'h03b5, 16'hffff);
        ctl(16'h0010, 1'b1);
        stat(16'h03b5, 16'hffff);
        ctl(16'h0002, 1'b1);
        stat(16'h03b1, 16'hffff);
        chk(irq, 1'b0);
        eot = 0;
        ctl(16'h0001, 1'b1);
        stat(16'h0091, 16'hffff);
        $display("test clearing done");
        // read with data interrupt, then lost data
        ctl(16'h0104, 1'b1);
        pulse(0);
        stat(16'h108f, 16'hffff);
        xfer(1'b1, tape_status_pkg::DCODE_DATA, 16'h0000);
        chk({rep, 9'h0, a[5:0]}, 16'h802a);
        stat(16'h1083, 16'hffff);
        chk(irq, 1'b0);
        pulse(0);
        pulse(0);
        stat(16'h10e3, 16'hfff7);
        xfer(1'b1, tape_status_pkg::DCODE_DATA, 16'h0000);
        chk({rep, rej, irq}, 3'h2);
        wait_idle();
        $display("test read done");
        // backspace ignores parity; unload sets no end of operation
        ctl(16'h0181, 1'b1);
        pulse(1);
        wait_idle();
        stat(16'h1091, 16'hffff);
        repeat (60) @(negedge clk);
        stat(16'h0091, 16'hffff);
        ctl(16'h0600, 1'b1);
        wait_idle();
        stat(16'h0081, 16'hefff);
        $display("test motion done");
        final_report();
    end
endmodule
